// ---- design/fbd_pkg.sv ----
// Function
// - banks 2 and 3 split into 32-kword sectors
// - non-read operations start by command writes
// - commands held in unaddressed latches driving state
// - bad sequence needs reset command or reset low to recover
// - read address phase: bus floats, ready high, low in burst mode
// - avd low read tracks address, drives data
// - avd high read drives latched location data
// - write address captured from avd strobe
// - write data captured on write-enable rise
// - chip select high: standby, floats outputs
// - reset low: abort burst, float outputs
// - burst start latches address on clock rise
// - burst advances each clock, ready high
// - avd low mid-burst restarts with new address
// - after reset device reads asynchronously
// - avd rise freezes the accessed address
// - burst only after configuration enables it
package fbd_pkg;
	localparam int          ADDR_W       = 22;
	localparam int          DATA_W       = 16;
	localparam logic [21:0] BANK2_START  = 22'h200000;
	localparam logic [21:0] BANK3_START  = 22'h300000;
	localparam logic [21:0] BANK3_END    = 22'h3FFFFF;
	localparam int          BANK_LSB     = 20;
	localparam int          SECTOR_LSB   = 15;
	localparam int          SECTOR_W     = 5;
	localparam logic [10:0] UNLOCK1_ADDR = 11'h555;
	localparam logic [10:0] UNLOCK2_ADDR = 11'h2AA;
	localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
	localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [15:0] CMD_PROGRAM  = 16'h00A0;
	localparam logic [15:0] CMD_CONFIG   = 16'h00D0;
	localparam logic [15:0] CMD_RESET    = 16'h00F0;
	localparam int          CFG_BURST_BIT = 0;
	localparam logic [15:0] MEM_ERASED   = 16'hFFFF;
	localparam logic [5:0]  PIN_IDLE     = 6'h3E;
	localparam int          PHASE_CYC    = 6;
	localparam int          FIFO_DEPTH   = 16;
	typedef enum logic [2:0] {
		FBD_READ, FBD_WRITE, FBD_BSTART, FBD_BNEXT, FBD_STOP, FBD_RESET
	} fbd_op_e;
	localparam int          CMD_W        = 3 + ADDR_W + DATA_W;
endpackage

// ---- design/fbd_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface fbd_if;
	import fbd_pkg::*;
	logic              chip_sel_n;
	logic              out_en_n;
	logic              wr_en_n;
	logic              address_valid_n;
	logic              hw_reset_n;
	logic              burst_clk;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] host_dq_out;
	logic              host_dq_oe;
	logic [DATA_W-1:0] dev_dq_out;
	logic              dev_dq_oe;
	logic              dev_rdy;
	logic              dev_rdy_oe;
	wire  [DATA_W-1:0] dq_bus;
	wire               rdy_bus;
	// shared wire resolution, undriven reads low
	assign dq_bus  = host_dq_oe ? host_dq_out : (dev_dq_oe ? dev_dq_out : '0);
	assign rdy_bus = dev_rdy_oe ? dev_rdy : 1'b0;
	modport dev (
		input  chip_sel_n, out_en_n, wr_en_n, address_valid_n, hw_reset_n,
		input  burst_clk, addr, dq_bus,
		output dev_dq_out, dev_dq_oe, dev_rdy, dev_rdy_oe
	);
	modport host (
		output chip_sel_n, out_en_n, wr_en_n, address_valid_n, hw_reset_n,
		output burst_clk, addr, host_dq_out, host_dq_oe,
		input  dq_bus, rdy_bus
	);
endinterface
`default_nettype wire

// ---- design/fbd_flash_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbd_flash_end #(
	parameter int MEM_WORDS = 16
) (
	input  wire logic                     mclk,
	input  wire logic                     sys_rst,
	input  wire logic                     clk_en,
	fbd_if.dev                            bus,
	output logic                          burst_mode,
	output logic                          acc_upper,
	output logic [1:0]                    acc_bank,
	output logic [fbd_pkg::SECTOR_W-1:0]  acc_sector,
	output logic                          seq_unknown,
	output logic                          prog_strobe
);
	import fbd_pkg::*;
	localparam int SYN_W = 6 + ADDR_W + DATA_W;
	localparam int IDX_W = $clog2(MEM_WORDS);

	typedef enum logic [2:0] {
		FBD_S_ARRAY, FBD_S_UNL1, FBD_S_UNL2, FBD_S_PROG, FBD_S_CFG, FBD_S_UNKNOWN
	} fbd_seq_e;

	logic [SYN_W-1:0]  raw_pins;
	logic [SYN_W-1:0]  sync1;
	logic [SYN_W-1:0]  sync2;
	logic              s_rst_n, s_ce_n, s_oe_n, s_we_n, s_avd_n, s_bclk;
	logic [ADDR_W-1:0] s_addr;
	logic [DATA_W-1:0] s_dq;
	logic              bclk_d, we_d;
	logic              bclk_rise, we_rise;
	logic              sel, rd_lat, rd_data, wr_adr, wr_dat;
	logic [ADDR_W-1:0] lat_addr;
	logic [ADDR_W-1:0] burst_addr;
	logic              burst_act, burst_first;
	logic [ADDR_W-1:0] rd_addr;
	logic [ADDR_W-1:0] acc_addr;
	fbd_seq_e          seq;
	logic              prog_we;
	logic [DATA_W-1:0] mem [MEM_WORDS];

	assign raw_pins = {bus.hw_reset_n, bus.chip_sel_n, bus.out_en_n, bus.wr_en_n,
		bus.address_valid_n, bus.burst_clk, bus.addr, bus.dq_bus};

	// two-stage pin synchroniser
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			sync1 <= {PIN_IDLE, {(ADDR_W + DATA_W){1'b0}}};
			sync2 <= {PIN_IDLE, {(ADDR_W + DATA_W){1'b0}}};
		end else if (clk_en) begin
			sync1 <= raw_pins;
			sync2 <= sync1;
		end
	end

	assign {s_rst_n, s_ce_n, s_oe_n, s_we_n, s_avd_n, s_bclk, s_addr, s_dq} = sync2;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bclk_d <= 1'b0;
			we_d   <= 1'b1;
		end else if (clk_en) begin
			bclk_d <= s_bclk;
			we_d   <= s_we_n;
		end
	end

	assign bclk_rise = s_bclk & ~bclk_d;
	assign we_rise   = s_we_n & ~we_d;

	assign sel     = s_rst_n & ~s_ce_n;
	assign rd_lat  = sel & s_oe_n & s_we_n & ~s_avd_n;
	assign rd_data = sel & ~s_oe_n & s_we_n;
	assign wr_adr  = sel & s_oe_n & ~s_we_n & ~s_avd_n;
	assign wr_dat  = sel & s_oe_n & we_rise & s_avd_n;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lat_addr <= '0;
		end else if (clk_en) begin
			if (wr_adr || (~s_avd_n && (rd_lat || rd_data))) begin
				lat_addr <= s_addr;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			burst_act   <= 1'b0;
			burst_first <= 1'b0;
			burst_addr  <= '0;
		end else if (clk_en) begin
			if (!sel) begin
				burst_act   <= 1'b0;
				burst_first <= 1'b0;
			end else if (rd_lat && burst_mode && bclk_rise) begin
				burst_act   <= 1'b1;
				burst_first <= 1'b1;
				burst_addr  <= s_addr;
			end else if (rd_data && s_avd_n && burst_act && bclk_rise) begin
				burst_first <= 1'b0;
				if (!burst_first) begin
					burst_addr <= burst_addr + 1'b1;
				end
			end
		end
	end

	assign rd_addr = burst_act ? burst_addr : (s_avd_n ? lat_addr : s_addr);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus.dev_dq_out <= '0;
			bus.dev_dq_oe  <= 1'b0;
			bus.dev_rdy    <= 1'b0;
			bus.dev_rdy_oe <= 1'b0;
		end else if (clk_en) begin
			bus.dev_dq_out <= mem[rd_addr[IDX_W-1:0]];
			bus.dev_dq_oe  <= rd_data && !(burst_act && burst_first);
			bus.dev_rdy_oe <= sel;
			bus.dev_rdy    <= sel && !(burst_act && burst_first)
				&& !(rd_lat && burst_mode);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			seq <= FBD_S_ARRAY;
		end else if (clk_en && !s_rst_n) begin
			seq <= FBD_S_ARRAY;
		end else if (clk_en && wr_dat) begin
			if (s_dq == CMD_RESET && seq != FBD_S_PROG && seq != FBD_S_CFG) begin
				seq <= FBD_S_ARRAY;
			end else begin
				case (seq)
					FBD_S_ARRAY: begin
						if (lat_addr[10:0] == UNLOCK1_ADDR && s_dq == UNLOCK1_DATA) begin
							seq <= FBD_S_UNL1;
						end else begin
							seq <= FBD_S_UNKNOWN;
						end
					end
					FBD_S_UNL1: begin
						if (lat_addr[10:0] == UNLOCK2_ADDR && s_dq == UNLOCK2_DATA) begin
							seq <= FBD_S_UNL2;
						end else begin
							seq <= FBD_S_UNKNOWN;
						end
					end
					FBD_S_UNL2: begin
						if (s_dq == CMD_PROGRAM) begin
							seq <= FBD_S_PROG;
						end else if (s_dq == CMD_CONFIG) begin
							seq <= FBD_S_CFG;
						end else begin
							seq <= FBD_S_UNKNOWN;
						end
					end
					FBD_S_PROG:    seq <= FBD_S_ARRAY;
					FBD_S_CFG:     seq <= FBD_S_ARRAY;
					FBD_S_UNKNOWN: seq <= FBD_S_UNKNOWN;
					default:       seq <= FBD_S_UNKNOWN;
				endcase
			end
		end
	end

	assign prog_we = wr_dat && seq == FBD_S_PROG;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			burst_mode <= 1'b0;
		end else if (clk_en) begin
			if (!s_rst_n) begin
				burst_mode <= 1'b0;
			end else if (wr_dat && seq == FBD_S_CFG) begin
				burst_mode <= s_dq[CFG_BURST_BIT];
			end
		end
	end

	// word storage
	for (genvar g = 0; g < MEM_WORDS; g++) begin : g_mem
		always_ff @(posedge mclk) begin
			if (sys_rst) begin
				mem[g] <= MEM_ERASED;
			end else if (clk_en && prog_we && lat_addr[IDX_W-1:0] == IDX_W'(g)) begin
				mem[g] <= s_dq;
			end
		end
	end

	assign acc_addr = burst_act ? burst_addr : lat_addr;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			acc_upper   <= 1'b0;
			acc_bank    <= 2'h0;
			acc_sector  <= '0;
			seq_unknown <= 1'b0;
			prog_strobe <= 1'b0;
		end else if (clk_en) begin
			acc_upper   <= acc_addr >= BANK2_START && acc_addr <= BANK3_END;
			acc_bank    <= acc_addr[BANK_LSB +: 2];
			acc_sector  <= (acc_addr >= BANK2_START) ? acc_addr[SECTOR_LSB +: SECTOR_W] : '0;
			seq_unknown <= seq == FBD_S_UNKNOWN;
			prog_strobe <= prog_we;
		end
	end
endmodule // fbd_flash_end
`default_nettype wire

// ---- design/fbd_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [PW:0]  wr_ptr;
	logic [PW:0]  rd_ptr;
	logic         push, pop;

	assign out_valid = wr_ptr != rd_ptr;
	assign in_ready  = !(wr_ptr[PW] != rd_ptr[PW] && wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
	assign push      = clk_en && in_valid && in_ready;
	assign pop       = clk_en && out_valid && out_ready;
	assign out_data  = store[rd_ptr[PW-1:0]];

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			store[wr_ptr[PW-1:0]] <= in_data;
		end
	end
endmodule // fbd_fifo

module fbd_host_end #(
	parameter int PHASE = fbd_pkg::PHASE_CYC,
	parameter int DEPTH = fbd_pkg::FIFO_DEPTH
) (
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en,
	fbd_if.host                              bus,
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire fbd_pkg::fbd_op_e            cmd_op,
	input  wire logic [fbd_pkg::ADDR_W-1:0]  cmd_addr,
	input  wire logic [fbd_pkg::DATA_W-1:0]  cmd_wdata,
	output logic                             rsp_valid,
	output logic [fbd_pkg::DATA_W-1:0]       rsp_data,
	output logic                             busy
);
	import fbd_pkg::*;
	localparam logic [7:0] PHASE_LAST = 8'(PHASE - 1);

	typedef enum logic [2:0] {FBD_H_IDLE, FBD_H_ADR, FBD_H_LAT, FBD_H_ACT, FBD_H_END} fbd_hst_e;

	fbd_hst_e          st;
	logic [7:0]        timer;
	logic              q_valid, q_take;
	logic [CMD_W-1:0]  q_data;
	fbd_op_e           op;
	fbd_op_e           q_op;
	logic [DATA_W-1:0] wdata;
	logic              phase_done;

	fbd_fifo #(.W(CMD_W), .DEPTH(DEPTH)) u_cmd_fifo (
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.in_data   ({cmd_op, cmd_addr, cmd_wdata}),
		.out_valid (q_valid),
		.out_ready (q_take),
		.out_data  (q_data)
	);

	assign q_take     = st == FBD_H_IDLE;
	assign q_op       = fbd_op_e'(q_data[CMD_W-1 -: 3]);
	assign phase_done = timer == 8'h00;
	assign busy       = st != FBD_H_IDLE || q_valid;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st                  <= FBD_H_IDLE;
			timer               <= 8'h00;
			op                  <= FBD_READ;
			wdata               <= '0;
			rsp_valid           <= 1'b0;
			rsp_data            <= '0;
			bus.chip_sel_n      <= 1'b1;
			bus.out_en_n        <= 1'b1;
			bus.wr_en_n         <= 1'b1;
			bus.address_valid_n <= 1'b1;
			bus.hw_reset_n      <= 1'b1;
			bus.burst_clk       <= 1'b0;
			bus.addr            <= '0;
			bus.host_dq_out     <= '0;
			bus.host_dq_oe      <= 1'b0;
		end else if (clk_en) begin
			rsp_valid <= 1'b0;
			if (st != FBD_H_IDLE && !phase_done) begin
				timer <= timer - 1'b1;
			end else begin
				timer <= PHASE_LAST;
				case (st)
					FBD_H_IDLE: begin
						if (q_valid) begin
							op    <= q_op;
							wdata <= q_data[DATA_W-1:0];
							case (q_op)
								FBD_READ, FBD_WRITE, FBD_BSTART: begin
									st                  <= FBD_H_ADR;
									bus.chip_sel_n      <= 1'b0;
									bus.address_valid_n <= 1'b0;
									bus.out_en_n        <= 1'b1;
									bus.wr_en_n         <= q_op != FBD_WRITE;
									bus.addr            <= q_data[DATA_W +: ADDR_W];
									bus.burst_clk       <= 1'b0;
								end
								FBD_BNEXT: begin
									st                  <= FBD_H_LAT;
									bus.chip_sel_n      <= 1'b0;
									bus.out_en_n        <= 1'b0;
									bus.address_valid_n <= 1'b1;
									bus.burst_clk       <= 1'b1;
								end
								FBD_STOP: begin
									st                  <= FBD_H_END;
									bus.chip_sel_n      <= 1'b1;
									bus.out_en_n        <= 1'b1;
									bus.address_valid_n <= 1'b1;
								end
								default: begin
									st                  <= FBD_H_END;
									bus.hw_reset_n      <= 1'b0;
								end
							endcase
						end else begin
							timer <= 8'h00;
						end
					end
					FBD_H_ADR: begin
						st <= FBD_H_LAT;
						if (op == FBD_BSTART) begin
							bus.burst_clk <= 1'b1;
						end else begin
							bus.address_valid_n <= 1'b1;
						end
					end
					FBD_H_LAT: begin
						st                  <= FBD_H_ACT;
						bus.burst_clk       <= 1'b0;
						bus.address_valid_n <= 1'b1;
						if (op == FBD_WRITE) begin
							bus.wr_en_n     <= 1'b0;
							bus.host_dq_out <= wdata;
							bus.host_dq_oe  <= 1'b1;
						end else begin
							bus.out_en_n <= 1'b0;
						end
					end
					FBD_H_ACT: begin
						st <= FBD_H_END;
						if (op == FBD_READ || op == FBD_BNEXT) begin
							rsp_valid <= 1'b1;
							rsp_data  <= bus.dq_bus;
						end
						bus.wr_en_n <= 1'b1;
					end
					FBD_H_END: begin
						st             <= FBD_H_IDLE;
						timer          <= 8'h00;
						bus.hw_reset_n <= 1'b1;
						bus.host_dq_oe <= 1'b0;
						if (op == FBD_READ || op == FBD_WRITE) begin
							bus.chip_sel_n <= 1'b1;
							bus.out_en_n   <= 1'b1;
						end
					end
					default: st <= FBD_H_IDLE;
				endcase
			end
		end
	end
endmodule // fbd_host_end
`default_nettype wire

// ---- bench/fbd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fbd_props (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic wr_en_n,
	input wire logic address_valid_n,
	input wire logic hw_reset_n,
	input wire logic burst_clk,
	input wire logic host_dq_oe,
	input wire logic dev_dq_oe,
	input wire logic dev_rdy,
	input wire logic dev_rdy_oe
);
	logic burst_seen;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst || !clk_en);
	// burst clock seen in this selection
	always_ff @(posedge mclk) begin
		if (sys_rst || chip_sel_n || !hw_reset_n) begin
			burst_seen <= 1'b0;
		end else if (clk_en && burst_clk) begin
			burst_seen <= 1'b1;
		end
	end
	a_standby_float: assert property (
		chip_sel_n [*5] |-> !dev_dq_oe && !dev_rdy_oe)
		else $error("outputs driven in standby");
	a_reset_float: assert property (
		!hw_reset_n [*5] |-> !dev_dq_oe && !dev_rdy_oe)
		else $error("outputs driven in hardware reset");
	a_oe_high_float: assert property (
		out_en_n [*5] |-> !dev_dq_oe)
		else $error("data driven with output enable high");
	a_no_contention: assert property (
		!(host_dq_oe && dev_dq_oe))
		else $error("both ends drive data");
	a_async_drive: assert property (
		(!chip_sel_n && !out_en_n && wr_en_n && !burst_seen) [*5]
		|-> dev_dq_oe && dev_rdy_oe && dev_rdy)
		else $error("async read not driving");
	a_burst_ready: assert property (
		$rose(burst_clk) && !chip_sel_n && !out_en_n && address_valid_n
		|-> ##[3:5] (dev_dq_oe && dev_rdy_oe && dev_rdy))
		else $error("burst advance without data");
	a_sel_rdy_on: assert property (
		(!chip_sel_n && hw_reset_n) [*5] |-> dev_rdy_oe)
		else $error("ready floats while selected");
	a_write_ready: assert property (
		(!chip_sel_n && !wr_en_n) [*5] |-> dev_rdy && !dev_dq_oe)
		else $error("write cycle ready or data wrong");
endmodule // fbd_props
`default_nettype wire

// ---- bench/flash_bus_operation_decode_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_bus_operation_decode_bench;
	import fbd_pkg::*;
	logic        mclk      = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        clk_en    = 1'b1;
	logic        cmd_valid = 1'b0;
	fbd_op_e     cmd_op    = FBD_READ;
	logic [21:0] cmd_addr  = 22'h000000;
	logic [15:0] cmd_wdata = 16'h0000;
	logic        cmd_ready, rsp_valid, busy, burst_mode, acc_upper, seq_unknown, prog_strobe;
	logic [15:0] rsp_data;
	logic [1:0]  acc_bank;
	logic [4:0]  acc_sector;
	logic [15:0] rq [$];
	int          error_cnt = 0, cmp_count = 0, cyc = 0, refused = 0, progs = 0, n;
	logic [21:0] ta [6] = '{22'h1FFFFF, 22'h200000, 22'h2F8000, 22'h300000, 22'h3FFFFF, 22'h2A8005};
	logic [7:0]  te [6] = '{8'h20, 8'hC0, 8'hDF, 8'hE0, 8'hFF, 8'hD5};
	logic [15:0] bx [4] = '{16'hC00A, 16'hC00B, 16'hC00C, 16'h5A5A};
	fbd_if i_fbd_if ();
	fbd_flash_end i_fbd_flash_end (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(i_fbd_if),
		.burst_mode(burst_mode), .acc_upper(acc_upper), .acc_bank(acc_bank),
		.acc_sector(acc_sector), .seq_unknown(seq_unknown), .prog_strobe(prog_strobe));
	fbd_host_end i_fbd_host_end (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .bus(i_fbd_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy(busy));
	fbd_props i_fbd_props (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
		.chip_sel_n(i_fbd_if.chip_sel_n), .out_en_n(i_fbd_if.out_en_n),
		.wr_en_n(i_fbd_if.wr_en_n), .address_valid_n(i_fbd_if.address_valid_n),
		.hw_reset_n(i_fbd_if.hw_reset_n), .burst_clk(i_fbd_if.burst_clk),
		.host_dq_oe(i_fbd_if.host_dq_oe), .dev_dq_oe(i_fbd_if.dev_dq_oe),
		.dev_rdy(i_fbd_if.dev_rdy), .dev_rdy_oe(i_fbd_if.dev_rdy_oe));
	always #12.5 mclk = ~mclk;
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic got(input logic [15:0] exp);
		check(rq.size() > 0 ? rq.pop_front() : 16'hXXXX, exp);
	endtask
	// offer one command, valid stays high
	task automatic push(input fbd_op_e op, input logic [21:0] a, input logic [15:0] d);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_addr = a;
		cmd_wdata = d;
		while (cmd_ready !== 1'b1) begin
			refused++;
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
	endtask
	task automatic rest();
		cmd_valid = 1'b0;
		while (busy !== 1'b0) begin
			@(posedge mclk);
			#1;
		end
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic rd(input logic [21:0] a, input logic [15:0] exp);
		push(FBD_READ, a, 16'h0000);
		rest();
		got(exp);
	endtask
	task automatic seq4(input logic [15:0] c, input logic [21:0] a, input logic [15:0] d);
		push(FBD_WRITE, {11'h000, UNLOCK1_ADDR}, UNLOCK1_DATA);
		push(FBD_WRITE, {11'h000, UNLOCK2_ADDR}, UNLOCK2_DATA);
		push(FBD_WRITE, {11'h000, UNLOCK1_ADDR}, c);
		push(FBD_WRITE, a, d);
		rest();
	endtask
	always @(posedge mclk) begin
		// pulses stand while frozen
		if (rsp_valid === 1'b1 && clk_en) rq.push_back(rsp_data);
		if (prog_strobe === 1'b1 && clk_en) progs++;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			$display("unexpected at %0t: timeout", $time);
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		rd(22'h000003, MEM_ERASED);
		check({15'h0, burst_mode}, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			rd(ta[i], MEM_ERASED);
			check({8'h00, acc_upper, acc_bank, acc_sector}, {8'h00, te[i]});
		end
		seq4(CMD_PROGRAM, 22'h2A8005, 16'h1234);
		check(16'(progs), 16'h0001);
		rd(22'h2A8005, 16'h1234);
		for (int i = 0; i < 3; i++) seq4(CMD_PROGRAM, 22'h30000A + 22'(i), 16'hC00A + 16'(i));
		push(FBD_WRITE, 22'h000555, 16'h0012);
		rest();
		check({15'h0, seq_unknown}, 16'h0001);
		seq4(CMD_PROGRAM, 22'h300008, 16'hBEEF);
		check(16'(progs), 16'h0004);
		push(FBD_WRITE, 22'h000000, CMD_RESET);
		rest();
		check({15'h0, seq_unknown}, 16'h0000);
		rd(22'h300008, MEM_ERASED);
		push(FBD_WRITE, 22'h000555, UNLOCK1_DATA);
		push(FBD_RESET, 22'h000000, 16'h0000);
		seq4(CMD_PROGRAM, 22'h300009, 16'h5A5A);
		check({15'h0, seq_unknown}, 16'h0000);
		rd(22'h300009, 16'h5A5A);
		seq4(CMD_CONFIG, 22'h000000, 16'h0001);
		check({15'h0, burst_mode}, 16'h0001);
		push(FBD_BSTART, 22'h30000A, 16'h0000);
		for (int i = 0; i < 3; i++) push(FBD_BNEXT, 22'h000000, 16'h0000);
		push(FBD_BSTART, 22'h300009, 16'h0000);
		push(FBD_BNEXT, 22'h000000, 16'h0000);
		push(FBD_STOP, 22'h000000, 16'h0000);
		push(FBD_RESET, 22'h000000, 16'h0000);
		rest();
		check(16'(rq.size()), 16'h0004);
		for (int i = 0; i < 4; i++) got(bx[i]);
		check({15'h0, burst_mode}, 16'h0000);
		refused = 0;
		for (int i = 0; i < 20; i++) push(FBD_READ, 22'h300009, 16'h0000);
		cmd_valid = 1'b0;
		clk_en = 1'b0;
		n = rq.size();
		repeat (30) @(posedge mclk);
		#1;
		check(16'(rq.size()), 16'(n));
		clk_en = 1'b1;
		rest();
		check({15'h0, refused > 0}, 16'h0001);
		check(16'(rq.size()), 16'h0014);
		for (int i = 0; i < 20; i++) got(16'h5A5A);
		final_report();
	end
endmodule // flash_bus_operation_decode_bench
`default_nettype wire
